// ===== cpu_bus_regs.svh
// timing constants and reset values for the processor bus control block
`ifndef CPU_BUS_REGS_SVH
`define CPU_BUS_REGS_SVH
`define CLK_PERIOD_NS 40
`define BUS_CYCLE_NS 1000
`define BUS_CYCLE_CLKS (`BUS_CYCLE_NS / `CLK_PERIOD_NS)
`define PHASE_CLKS (`BUS_CYCLE_CLKS / 2)
`define ADDR_RESET 16'h0000
`define DATA_RESET 8'h00
`endif

// ===== cpu_bus_pkg.sv
// types shared by the processor bus control block
`default_nettype none
package cpu_bus_pkg;
    typedef enum logic [2:0] {
        st_run  = 3'b001,
        st_halt = 3'b010,
        st_idle = 3'b100
    } bus_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
    } bus_req_t;
endpackage
`default_nettype wire

// ===== cpu_bus_drive.sv
// processor bus side: two-phase clock generator, data drive gate and ready stall
// Overview of operation
// - on-chip generator derives phase one and phase two from the time base.
// - eight-bit bidirectional data bus with tri-state output drivers.
// - data drivers enabled only while the bus gate input is high.
// - data drivers disabled during every read cycle.
// - ready low at the end of a read cycle, after phase two, halts, address held.
// - halt persists while ready is low; resume once ready is high.
// - ready low ignored in writes; stall honoured at the next read.
// - interrupt requests accepted only while ready is high.
`include "cpu_bus_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_drive #(
    parameter int CYCLE_CLKS = `BUS_CYCLE_CLKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // external control pins
    input wire logic data_bus_output_gate,
    input wire logic ready,
    input wire logic irq_req,
    // core side: next bus request and its acceptance
    input wire cpu_bus_pkg::bus_req_t core_req,
    output logic core_advance,
    output logic irq_accept,
    output logic [7:0] core_rdata,
    // generated phases
    output logic phase1,
    output logic phase2,
    // bus pins
    output logic [15:0] address_lines,
    output logic rw_n_write,
    input wire logic [7:0] data_lines_in,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe,
    // state
    output logic halted
);
    localparam int HALF = CYCLE_CLKS / 2;
    localparam int CW = $clog2(CYCLE_CLKS + 1);

    logic [CW-1:0] cnt_ff;
    logic phase1_ff;
    logic phase2_ff;
    cpu_bus_pkg::bus_state_t state_ff;
    logic [15:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    logic write_ff;

    // divider decode: the count wraps once per bus cycle, so every phase is a count window
    wire cycle_end = (cnt_ff == CW'(CYCLE_CLKS - 1));
    wire [CW-1:0] nxt_cnt = cycle_end ? '0 : cnt_ff + CW'(1);
    // idle counts at the start, the middle and the end keep the two phases apart
    wire nxt_phase1 = (nxt_cnt != '0) && (nxt_cnt < CW'(HALF));
    wire nxt_phase2 = (nxt_cnt > CW'(HALF)) && (nxt_cnt != CW'(CYCLE_CLKS - 1));

    // cycle qualifiers; the idle cycle after reset carries no data and never stalls
    wire idle = (state_ff == cpu_bus_pkg::st_idle);
    wire stalled = (state_ff == cpu_bus_pkg::st_halt);
    wire rd_cycle = !write_ff && !idle;
    // ready is judged only at the cycle boundary; a read with ready low there stretches
    wire read_stall = rd_cycle && !ready;
    wire advance = cycle_end && !read_stall;

    // phase counter is the divider that makes the two phases
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // phases come from flip-flops so a decode glitch never reaches the clock outputs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase1_ff <= 1'b0;
            phase2_ff <= 1'b0;
        end else begin
            phase1_ff <= nxt_phase1;
            phase2_ff <= nxt_phase2;
        end
    end

    // bus cycle state; address and direction only reload at the cycle boundary, one clock before phase one rises
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= cpu_bus_pkg::st_idle;
            addr_ff <= `ADDR_RESET;
            wdata_ff <= `DATA_RESET;
            write_ff <= 1'b0;
        end else if (cycle_end) begin
            unique case (state_ff)
                cpu_bus_pkg::st_idle: begin
                    state_ff <= cpu_bus_pkg::st_run;
                    addr_ff <= core_req.addr;
                    wdata_ff <= core_req.wdata;
                    write_ff <= core_req.write;
                end
                cpu_bus_pkg::st_run, cpu_bus_pkg::st_halt: begin
                    if (read_stall) begin
                        state_ff <= cpu_bus_pkg::st_halt; // address kept
                    end else begin
                        state_ff <= cpu_bus_pkg::st_run;
                        addr_ff <= core_req.addr;
                        wdata_ff <= core_req.wdata;
                        write_ff <= core_req.write;
                    end
                end
            endcase
        end
    end

    // read data is captured at the boundary that completes a read, one clock after phase two ends
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= `DATA_RESET;
        end else if (advance && rd_cycle) begin
            rdata_ff <= data_lines_in;
        end
    end

    // drivers: gate input alone cannot enable a read; writes still need the gate high
    assign data_lines_oe = data_bus_output_gate && write_ff && !idle;
    assign data_lines_out = wdata_ff;
    assign address_lines = addr_ff;
    assign rw_n_write = !write_ff;
    assign phase1 = phase1_ff;
    assign phase2 = phase2_ff;
    assign core_rdata = rdata_ff;
    assign core_advance = advance;
    assign halted = stalled;
    // a stalled core takes no interrupt; ready must be high at the boundary
    assign irq_accept = irq_req && ready && advance;

    // steps of a stretched read: the refusing boundary, the held cycle, the resuming boundary; and a write boundary with ready low
    sequence s_read_refused;
        cycle_end && rd_cycle && !ready;
    endsequence
    sequence s_held_cycle;
        halted && $stable(address_lines) && $stable(rw_n_write);
    endsequence
    sequence s_resume_point;
        cycle_end && halted && ready;
    endsequence
    sequence s_write_boundary;
        cycle_end && write_ff && !idle && !ready;
    endsequence

    // drive gate: a low gate input overrides everything, and reads never drive
    a_gate_low_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        !data_bus_output_gate |-> !data_lines_oe)
        else $error("drivers on with gate low");
    a_gate_write_on: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_bus_output_gate && !rw_n_write) |-> data_lines_oe)
        else $error("write not driven with gate high");
    a_read_no_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        rw_n_write |-> !data_lines_oe)
        else $error("drivers on in read");
    a_halt_no_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        halted |-> !data_lines_oe)
        else $error("drivers on while halted");

    // stretched reads hold the bus; writes ignore ready and finish
    a_halt_holds_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_read_refused |=> s_held_cycle)
        else $error("read stall lost address");
    a_halt_persists: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cycle_end && halted && !ready) |=> s_held_cycle)
        else $error("halt left with ready low");
    a_resume_on_ready: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_resume_point |=> !halted)
        else $error("no resume");
    a_halt_no_advance: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_read_refused |-> !core_advance)
        else $error("refused read advanced");
    a_halt_is_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        halted |-> rw_n_write)
        else $error("halt outside a read");
    a_write_ignores: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_write_boundary |-> core_advance ##1 !halted)
        else $error("write stalled");

    // interrupts only with ready high; read data is the bus value at the completing boundary
    a_irq_ready: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_accept |-> (ready && core_advance))
        else $error("irq while stalled");
    a_halt_no_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
        (halted && !ready) |-> !irq_accept)
        else $error("irq taken in halt");
    a_rdata_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cycle_end && rd_cycle && ready) |=> (core_rdata == $past(data_lines_in)))
        else $error("read data not captured");

    // address and direction move only as a new cycle starts
    a_addr_boundary: assert property (@(posedge ref_clk) disable iff (!nrst)
        !$stable(address_lines) |-> $past(cycle_end))
        else $error("address moved mid cycle");
    a_dir_boundary: assert property (@(posedge ref_clk) disable iff (!nrst)
        !$stable(rw_n_write) |-> $past(cycle_end))
        else $error("direction moved mid cycle");
    a_idle_takes: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cycle_end && idle) |=> !idle)
        else $error("first request not taken");

    // phase outputs stay apart and start at fixed counts of the divider
    a_phase_apart: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(phase1 && phase2))
        else $error("phases overlap");
    a_phase1_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(phase1) |-> (cnt_ff == CW'(1)))
        else $error("phase one starts off count");
    a_phase2_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(phase2) |-> (cnt_ff == CW'(HALF + 1)))
        else $error("phase two starts off count");
endmodule
`default_nettype wire

// ===== mem_model.sv
// slow memory model on the far side of the processor bus
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    // bus side
    input wire logic ref_clk,
    input wire logic phase1,
    input wire logic [15:0] address_lines,
    input wire logic rw_n_write,
    // bench control and answers
    input wire logic hold_low,
    output logic ready,
    output logic [7:0] data_lines_in
);
    logic p1_q = 1'b0;
    logic [1:0] waits = 2'h0;
    logic [15:0] last = 16'h0000;
    logic [7:0] prev = 8'h00;
    // upper half is slow: a read there waits two bus cycles, never more
    always @(posedge ref_clk) begin
        p1_q <= phase1;
        prev <= data_lines_in;
        if (phase1 && !p1_q) begin
            last <= address_lines;
            if (address_lines != last) waits <= (rw_n_write & address_lines[15]) ? 2'h2 : 2'h0;
            else if (waits != 2'h0) waits <= waits - 2'h1;
        end
    end
    // undriven data toggles every clock so a stale value never looks valid
    assign ready = (waits == 2'h0) & !hold_low;
    assign data_lines_in = rw_n_write ? (address_lines[7:0] ^ 8'h5a) : ~prev;
endmodule
`default_nettype wire

// ===== tb_cpu_bus_drive_and_ready_stall.sv
// self-checking bench for the bus drive gate and ready stall
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_bus_drive_and_ready_stall;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic gate_en = 1'b1;
    logic gate;
    logic hold_low = 1'b0;
    logic irq_req = 1'b0;
    cpu_bus_pkg::bus_req_t req = '0;
    logic core_advance, irq_accept, phase1, phase2, rw_n_write, data_lines_oe, halted, ready;
    logic [7:0] core_rdata, data_lines_out, data_lines_in;
    logic [15:0] address_lines;
    int failures = 0;
    int cmp_count = 0;
    cpu_bus_drive #(.CYCLE_CLKS(6)) u_cpu_bus_drive (.ref_clk(ref_clk), .nrst(nrst),
        .data_bus_output_gate(gate), .ready(ready), .irq_req(irq_req), .core_req(req),
        .core_advance(core_advance), .irq_accept(irq_accept), .core_rdata(core_rdata), .phase1(phase1),
        .phase2(phase2), .address_lines(address_lines), .rw_n_write(rw_n_write),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
        .halted(halted));
    mem_model u_mem_model (.ref_clk(ref_clk), .phase1(phase1), .address_lines(address_lines),
        .rw_n_write(rw_n_write), .hold_low(hold_low), .ready(ready), .data_lines_in(data_lines_in));
    // clock source: the only time base, both phases are derived from it
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // gate follows phase two, as the system ties it, masked by gate_en for the gate-low test
    assign gate = phase2 & gate_en;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one bus cycle, watched from take to completion; slow means a halt is due
    task automatic bus_op(input logic [15:0] a, input logic [7:0] d, input logic w, input logic slow);
        int n;
        int hc;
        logic oe_seen;
        hc = 0;
        oe_seen = 0;
        n = 0;
        req <= '{a, d, w};
        irq_req <= a[0];
        do begin
            @(posedge ref_clk);
            n++;
        end while (!core_advance && n < 100);
        check(n < 100, 1'b1);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (n == 30) hold_low <= 1'b0;
            hc += halted;
            oe_seen |= data_lines_oe;
            check(phase1 & phase2, 1'b0);
            if (!ready || (halted && !core_advance)) check(irq_accept, 1'b0);
            if (data_lines_oe) check({gate, data_lines_out}, {1'b1, d});
            if (!w) check(data_lines_oe, 1'b0);
            if (halted) check(address_lines, a);
        end while (!core_advance && n < 100);
        check(n < 100, 1'b1);
        check(irq_accept, irq_req & ready);
        check(address_lines, a);
        check(rw_n_write, !w);
        check(hc > 0, slow);
        if (w) check(oe_seen, gate_en);
        if (!w) begin
            @(posedge ref_clk);
            check(core_rdata, a[7:0] ^ 8'h5a);
        end
    endtask
    task automatic t_back_to_back;
        bus_op(16'h0123, 8'h00, 1'b0, 1'b0);
        bus_op(16'h0456, 8'ha5, 1'b1, 1'b0);
        bus_op(16'h0457, 8'h3c, 1'b1, 1'b0);
    endtask
    task automatic t_gate_low;
        gate_en <= 1'b0;
        bus_op(16'h0300, 8'h81, 1'b1, 1'b0);
        gate_en <= 1'b1;
    endtask
    task automatic t_write_then_stall;
        hold_low <= 1'b1;
        bus_op(16'h0200, 8'h77, 1'b1, 1'b0);
        bus_op(16'h0201, 8'h00, 1'b0, 1'b1);
        bus_op(16'h8123, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic wrap_up;
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence after a 16-clock reset
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        t_back_to_back();
        t_gate_low();
        t_write_then_stall();
        wrap_up();
    end
    // hang guard, far beyond the few dozen bus cycles used
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
